// File: rtl/adc_pin_mode_pkg.sv
// Purpose: Shared constants for the converter pin-mode select block.
// Assumes: 32-bit Avalon-MM register bus with byte addresses.
// Notes:   Register offsets are byte addresses, one word each.
`default_nettype none
package adc_pin_mode_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int        ADDR_W        = 4;
    localparam int        DATA_W        = 32;
    localparam int        FS_W          = 8;
    localparam logic [3:0] OFF_CONTROL  = 4'h0;
    localparam logic [3:0] OFF_STATUS   = 4'h4;
    localparam logic [3:0] OFF_FS_ADJ   = 4'h8;
    // Field positions.
    localparam int        CTL_CAL_START = 0;
    localparam int        ST_CAL_ACTIVE = 0;
    localparam int        ST_EXT_ACTIVE = 1;
    localparam int        ST_DIFF_RST   = 2;
    localparam int        ST_AC_COUPLE  = 3;
    localparam int        ST_ALT_EXT    = 4;
    localparam int        ST_FS_HIGH    = 5;
    localparam int        ST_FS_PIN     = 6;
    // Reset values.
    localparam logic [FS_W-1:0]   FS_ADJ_RESET = 8'h80;
    localparam logic [DATA_W-1:0] ZERO_WORD    = 32'h0000_0000;
    // Default calibration length in clock cycles.
    localparam int        CAL_CYCLES_DEF = 1024;
    // Calibration sequencer states.
    typedef enum logic {CAL_IDLE, CAL_RUN} cal_state_e;
endpackage : adc_pin_mode_pkg
`default_nettype wire

// File: rtl/adc_pin_mode_select.sv
// Purpose: Pin-strap mode decode and calibration indicator of a converter.
// Assumes: sys_clk 200 MHz; strap pins are asynchronous to it.
// Notes:   Registers on Avalon-MM; answers one cycle after a request.
//
// Implementation choices: the register addresses and the Avalon-MM register port.
`default_nettype none
module adc_pin_mode_select
    import adc_pin_mode_pkg::*;
#(
    parameter int CAL_CYCLES = CAL_CYCLES_DEF
) (
    // Clock and reset.
    input  wire logic                          sys_clk,
    input  wire logic                          rst,
    // Avalon-MM slave.
    input  wire logic [adc_pin_mode_pkg::ADDR_W-1:0] address,
    input  wire logic                          read,
    input  wire logic                          write,
    input  wire logic [adc_pin_mode_pkg::DATA_W-1:0] writedata,
    output logic      [adc_pin_mode_pkg::DATA_W-1:0] readdata,
    output logic                               waitrequest,
    // Strap and shared pins.
    input  wire logic                          extended_ctrl_select_n,
    input  wire logic                          clock_reset_style_select,
    input  wire logic                          sharedRangePin,
    input  wire logic                          clockResetPosPin,
    input  wire logic                          commonModeSense,
    // Decoded modes and indicator.
    output logic                               calibration_active_flag,
    output logic                               extendedCtrlActive,
    output logic                               differentialReset,
    output logic                               output_clock_reset,
    output logic                               acCouplingMode,
    output logic                               alternate_extended_ctrl_select,
    output logic                               full_scale_range_select,
    output logic      [adc_pin_mode_pkg::FS_W-1:0] fullScaleCode
);
    import adc_pin_mode_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    localparam int NPIN = 5;
    logic [NPIN-1:0] pinRaw;
    logic [NPIN-1:0] pinMeta_q;
    logic [NPIN-1:0] pinSync_q;
    logic [NPIN-1:0] pinMeta_d;
    logic [NPIN-1:0] pinSync_d;

    assign pinRaw = {commonModeSense, clockResetPosPin, sharedRangePin,
                     clock_reset_style_select, extended_ctrl_select_n};

    // Two flops per pin; only the second stage is read by logic.
    always_comb begin
        pinMeta_d = pinRaw;
        pinSync_d = pinMeta_q;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pinMeta_q <= '1;
            pinSync_q <= '1;
        end else begin
            pinMeta_q <= pinMeta_d;
            pinSync_q <= pinSync_d;
        end
    end

    logic extSelN;
    logic styleHigh;
    logic rangePin;
    logic rstPos;
    logic cmLevel;
    assign {cmLevel, rstPos, rangePin, styleHigh, extSelN} = pinSync_q;

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    logic [FS_W-1:0] fsAdj_q;

    // Decode follows the synchronised levels with no state in between.
    always_comb begin
        extendedCtrlActive = !extSelN;
        differentialReset  = !styleHigh;
        // Single-ended reset uses the positive pin; differential takes
        // the pair, asserted when plus is high and minus is low.
        output_clock_reset = styleHigh ? rstPos
                                       : (rstPos && !rangePin);
        alternate_extended_ctrl_select = styleHigh && rangePin;
        full_scale_range_select = styleHigh ? rangePin : 1'b1;
        fullScaleCode = extendedCtrlActive ? fsAdj_q
                                           : '0;
        acCouplingMode = !cmLevel;
    end

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    logic              resp_q;
    logic              resp_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic              wrDone;
    logic              calStart;
    logic [FS_W-1:0]   fsAdj_d;
    logic [DATA_W-1:0] statusWord;

    function automatic logic hits(input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] off);
        return a == off;
    endfunction : hits

    // Each request stalls one cycle, then completes.
    assign waitrequest = (read || write) && !resp_q;
    assign wrDone      = write && resp_q;
    assign readdata    = rdata_q;

    always_comb begin
        statusWord = ZERO_WORD;
        statusWord[ST_CAL_ACTIVE] = calibration_active_flag;
        statusWord[ST_EXT_ACTIVE] = extendedCtrlActive;
        statusWord[ST_DIFF_RST]   = differentialReset;
        statusWord[ST_AC_COUPLE]  = acCouplingMode;
        statusWord[ST_ALT_EXT]    = alternate_extended_ctrl_select;
        statusWord[ST_FS_HIGH]    = full_scale_range_select;
        statusWord[ST_FS_PIN]     = rangePin;
    end

    // Read data is captured on the stall cycle; unmapped reads give 0.
    always_comb begin
        resp_d   = (read || write) && !resp_q;
        rdata_d  = rdata_q;
        fsAdj_d  = fsAdj_q;
        calStart = wrDone && hits(address, OFF_CONTROL)
                   && writedata[CTL_CAL_START];
        if (read && !resp_q) begin
            if (hits(address, OFF_STATUS)) begin
                rdata_d = statusWord;
            end else if (hits(address, OFF_FS_ADJ)) begin
                rdata_d = {{(DATA_W-FS_W){1'b0}}, fsAdj_q};
            end else begin
                rdata_d = ZERO_WORD;
            end
        end
        // Adjust is only writable while extended control is active.
        if (wrDone && hits(address, OFF_FS_ADJ) && extendedCtrlActive) begin
            fsAdj_d = writedata[FS_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            resp_q  <= 1'b0;
            rdata_q <= ZERO_WORD;
            fsAdj_q <= FS_ADJ_RESET;
        end else begin
            resp_q  <= resp_d;
            rdata_q <= rdata_d;
            fsAdj_q <= fsAdj_d;
        end
    end

    // ------------------------------------------------------------------
    // Calibration sequencer
    // ------------------------------------------------------------------
    localparam int CW = $clog2(CAL_CYCLES + 1);
    localparam logic [CW-1:0] CAL_LAST = CW'(CAL_CYCLES - 1);
    cal_state_e    calState_q;
    cal_state_e    calState_d;
    logic [CW-1:0] calCnt_q;
    logic [CW-1:0] calCnt_d;

    // A start request while running is ignored.
    always_comb begin
        calState_d = calState_q;
        calCnt_d   = calCnt_q;
        unique case (calState_q)
            CAL_IDLE: begin
                if (calStart) begin
                    calState_d = CAL_RUN;
                    calCnt_d   = '0;
                end
            end
            CAL_RUN: begin
                calCnt_d = calCnt_q + CW'(1);
                if (calCnt_q == CAL_LAST) begin
                    calState_d = CAL_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            calState_q <= CAL_IDLE;
            calCnt_q   <= '0;
        end else begin
            calState_q <= calState_d;
            calCnt_q   <= calCnt_d;
        end
    end

    assign calibration_active_flag = (calState_q == CAL_RUN);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_cal_start_rises: assert property (
        calStart && !calibration_active_flag |=> calibration_active_flag)
        else $error("Calibration did not start.");
    a_cal_length: assert property (
        $rose(calibration_active_flag) |->
        calibration_active_flag [*8])
        else $error("Calibration ended too early.");
    a_ext_follows_pin: assert property (
        extSelN |-> !extendedCtrlActive && fullScaleCode == '0)
        else $error("Extended control active with select pin high.");
    a_ext_pin_latency: assert property (
        $stable(extended_ctrl_select_n) [*3] |->
        extendedCtrlActive == !extended_ctrl_select_n)
        else $error("Extended control lags its pin.");
    a_alt_no_override: assert property (
        extSelN && alternate_extended_ctrl_select |-> !extendedCtrlActive)
        else $error("Alternate enable overrode the select pin.");
    a_single_ended_rst: assert property (
        styleHigh |-> output_clock_reset == rstPos
                      && full_scale_range_select == rangePin)
        else $error("Single-ended mode decode wrong.");
    a_diff_rst_range: assert property (
        differentialReset |-> full_scale_range_select
        && !alternate_extended_ctrl_select
        && output_clock_reset == (rstPos && !rangePin))
        else $error("Differential mode decode wrong.");
    a_fs_adj_locked: assert property (
        extSelN |=> $stable(fsAdj_q))
        else $error("Adjust changed without extended control.");
    a_ac_couple: assert property (
        acCouplingMode != cmLevel)
        else $error("Coupling mode does not follow pin.");
    a_bus_one_wait: assert property (
        $rose(read) && waitrequest |=> !waitrequest)
        else $error("Bus answer not one cycle late.");

    c_cal_run: cover property ($fell(calibration_active_flag));
    c_fs_write: cover property (wrDone && hits(address, OFF_FS_ADJ)
                                && extendedCtrlActive);
    c_diff_mode: cover property (differentialReset && output_clock_reset);
    c_ac_mode: cover property (acCouplingMode && extendedCtrlActive);
endmodule : adc_pin_mode_select
`default_nettype wire

// File: tb/adc_strap_model.sv
// Purpose: Board strap model that drives the converter's config pins.
// Assumes: Strap levels change only when the bench asks for it.
// Notes:   A floating style pin is pulled high, as on the board.
`default_nettype none
module adc_strap_model (
    // Requests from the bench.
    input  wire logic [1:0] styleMode,
    input  wire logic       wantExtended,
    input  wire logic       acCoupled,
    input  wire logic       sharedLevel,
    input  wire logic       posLevel,
    // Strap pins.
    output wire logic       selectN,
    output wire logic       styleSel,
    output wire logic       sharedPin,
    output wire logic       posPin,
    output wire logic       cmPin
);
    timeunit 1ns;
    timeprecision 1ps;
    tri1 styleNet;
    // Mode 0 floats the style pin, mode 1 drives high, mode 2 drives low.
    assign styleNet  = (styleMode == 2'h0) ? 1'bz : styleMode[0];
    assign styleSel  = styleNet;
    // The select pin is low when extended control is wanted.
    assign selectN   = !wantExtended;
    // A.c. coupled inputs mean the common-mode pin is grounded.
    assign cmPin     = !acCoupled;
    assign sharedPin = sharedLevel;
    assign posPin    = posLevel;
endmodule : adc_strap_model
`default_nettype wire

// File: tb/adc_pin_mode_select_tb_top.sv
// Purpose: Self-checking bench of the converter pin-mode select block.
// Assumes: Pin changes settle within four clock edges.
// Notes:   Calibration is shortened to 16 cycles.
`default_nettype none
module adc_pin_mode_select_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_pin_mode_pkg::*;
    localparam int CAL_N = 16;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic              sys_clk   = 1'b0;
    logic              rst       = 1'b1;
    logic [ADDR_W-1:0] address   = 4'h0;
    logic              read      = 1'b0;
    logic              write     = 1'b0;
    logic [DATA_W-1:0] writedata = ZERO_WORD;
    logic [DATA_W-1:0] readdata, q;
    logic              waitrequest, calFlag, extAct, diffRst, clkRst;
    logic              acMode, altSel, rangeSel;
    logic [FS_W-1:0]   fsCode;
    logic [1:0]        styleMode = 2'h0;
    logic              wantExt = 1'b0, acCpl = 1'b0;
    logic              shLvl = 1'b0, posLvl = 1'b0;
    wire logic         selN, styleS, shPin, posPin, cmPin;
    int                err_total = 0;
    int                n_compared = 0;
    int                n;

    // Clock toggles every 2.5 ns, a period of 5 ns.
    always #2.5 sys_clk = ~sys_clk;

    adc_strap_model board (.styleMode(styleMode), .wantExtended(wantExt),
        .acCoupled(acCpl), .sharedLevel(shLvl), .posLevel(posLvl),
        .selectN(selN), .styleSel(styleS), .sharedPin(shPin),
        .posPin(posPin), .cmPin(cmPin));

    adc_pin_mode_select #(.CAL_CYCLES(CAL_N)) dut (.sys_clk(sys_clk),
        .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .extended_ctrl_select_n(selN),
        .clock_reset_style_select(styleS), .sharedRangePin(shPin),
        .clockResetPosPin(posPin), .commonModeSense(cmPin),
        .calibration_active_flag(calFlag), .extendedCtrlActive(extAct),
        .differentialReset(diffRst), .output_clock_reset(clkRst),
        .acCouplingMode(acMode), .alternate_extended_ctrl_select(altSel),
        .full_scale_range_select(rangeSel), .fullScaleCode(fsCode));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    // Prints the verdict and ends the run.
    task automatic close_out;
        if (err_total == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    // Compares one result word and reports a mismatch.
    task automatic check(input logic [DATA_W-1:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask : check

    // One Avalon transfer held until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
        int k;
        k = 0;
        @(posedge sys_clk);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        do begin
            @(posedge sys_clk);
            k++;
        end while (waitrequest !== 1'b0 && k < 50);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (k >= 50) err_total++;
    endtask : bus

    // Lets synchronized pin levels reach the outputs.
    task automatic settle;
        repeat (4) @(posedge sys_clk);
    endtask : settle

    // Reads status and compares every decoded output except fullScaleCode with the straps.
    task automatic check_state;
        logic st;
        st = (styleMode != 2'h2);
        bus(1'b0, OFF_STATUS, ZERO_WORD);
        check(q, DATA_W'({shLvl, st ? shLvl : 1'b1, st & shLvl, acCpl,
            !st, wantExt, 1'b0}));
        check(DATA_W'(extAct), DATA_W'(wantExt));
        check(DATA_W'(diffRst), DATA_W'(!st));
        check(DATA_W'(rangeSel), DATA_W'(st ? shLvl : 1'b1));
        check(DATA_W'(altSel), DATA_W'(st & shLvl));
        check(DATA_W'(acMode), DATA_W'(acCpl));
        check(DATA_W'(clkRst), DATA_W'(st ? posLvl : posLvl & !shLvl));
        check(DATA_W'(calFlag), ZERO_WORD);
    endtask : check_state

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    // Watchdog cuts a hang short.
    initial begin
        #100000;
        err_total++;
        close_out();
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        // Every style mode against every strap combination.
        for (int i = 0; i < 48; i++) begin
            @(posedge sys_clk);
            styleMode <= 2'(i % 3);
            {acCpl, posLvl, shLvl, wantExt} <= 4'(i / 3);
            settle();
            check_state();
        end
        // Adjust writes only count while extended control is active.
        @(posedge sys_clk);
        {acCpl, posLvl, shLvl, wantExt, styleMode} <= 6'h01;
        // Let the raised select level reach the decode first.
        settle();
        bus(1'b1, OFF_FS_ADJ, 32'h0000_0012);
        wantExt <= 1'b1;
        settle();
        check(DATA_W'(fsCode), DATA_W'(FS_ADJ_RESET));
        bus(1'b1, OFF_FS_ADJ, 32'h0000_005A);
        // The write lands on the completing edge; look one edge later.
        @(posedge sys_clk);
        check(DATA_W'(fsCode), 32'h0000_005A);
        styleMode <= 2'h2;
        settle();
        bus(1'b1, OFF_FS_ADJ, 32'h0000_003C);
        bus(1'b0, OFF_FS_ADJ, ZERO_WORD);
        check(q, 32'h0000_003C);
        wantExt <= 1'b0;
        settle();
        check(DATA_W'(fsCode), ZERO_WORD);
        bus(1'b1, OFF_FS_ADJ, 32'h0000_0077);
        wantExt <= 1'b1;
        settle();
        check(DATA_W'(fsCode), 32'h0000_003C);
        bus(1'b0, 4'hC, ZERO_WORD);
        check(q, ZERO_WORD);
        // Calibration flag stays high for exactly the calibration length.
        bus(1'b1, OFF_CONTROL, 32'h0000_0001);
        n = 0;
        for (int i = 0; i < 4 && calFlag !== 1'b1; i++) @(posedge sys_clk);
        while (calFlag === 1'b1 && n < 100) begin
            n++;
            @(posedge sys_clk);
        end
        check(DATA_W'(n), DATA_W'(CAL_N));
        check(DATA_W'(calFlag), ZERO_WORD);
        close_out();
    end
endmodule : adc_pin_mode_select_tb_top
`default_nettype wire
